/* inc/ppg_pkg.sv */
// Constants and register map of the multi-channel power PWM generator
package ppg_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int CH_MAX = 15;
   // Global registers, upper address nibble zero
   localparam logic [3:0] TB_CTRL_OFS = 4'h0;
   localparam logic [3:0] PERIOD_OFS = 4'h1;
   localparam logic [3:0] MDUTY_OFS = 4'h2;
   localparam logic [3:0] SEV_OFS = 4'h3;
   localparam logic [3:0] INT_STAT_OFS = 4'h4;
   localparam logic [3:0] INT_MASK_OFS = 4'h5;
   localparam logic [3:0] TB_CNT_OFS = 4'h6;
   // Channel registers, upper address nibble is channel plus one
   localparam logic [3:0] CH_CTRL_OFS = 4'h0;
   localparam logic [3:0] DUTY_OFS = 4'h1;
   localparam logic [3:0] PHASE_OFS = 4'h2;
   localparam logic [3:0] DEAD_OFS = 4'h3;
   localparam logic [3:0] OUT_CTRL_OFS = 4'h4;
   localparam logic [3:0] TRIG_OFS = 4'h5;
   localparam logic [3:0] STRIG_OFS = 4'h6;
   localparam logic [3:0] TRG_CTRL_OFS = 4'h7;
   localparam logic [3:0] CH_PERIOD_OFS = 4'h8;
   localparam logic [3:0] CH_CNT_OFS = 4'h9;
   // Time-base control fields
   localparam int MODULE_ENABLE_BIT = 15;
   localparam int IMMEDIATE_PERIOD_UPDATE_BIT = 10;
   // Channel control fields
   localparam int INDEPENDENT_TIME_BASE_SEL = 9;
   localparam int MASTER_DUTY_SEL = 8;
   localparam int IMMEDIATE_UPDATE_BIT = 0;
   // Output control fields
   localparam int HIGH_PIN_OWNERSHIP = 15;
   localparam int LOW_PIN_OWNERSHIP = 14;
   localparam int MODE_HI = 11;
   localparam int MODE_LO = 10;
   localparam int HIGH_OVERRIDE_ENABLE = 9;
   localparam int LOW_OVERRIDE_ENABLE = 8;
   localparam int OVR_DATA_HI = 7;
   localparam int OVR_DATA_LO = 6;
   localparam int SWAP_BIT = 1;
   localparam int OVR_SYNC_BIT = 0;
   // Trigger control fields
   localparam int TRG_DIV_HI = 15;
   localparam int TRG_DIV_LO = 12;
   localparam int TRG_STRT_HI = 5;
   localparam int TRG_STRT_LO = 0;
   typedef enum logic [1:0] {
      MODE_COMP = 2'b00,
      MODE_REDUNDANT = 2'b01,
      MODE_PUSH_PULL = 2'b10,
      MODE_INDEP = 2'b11
   } ppg_mode_t;
   localparam logic [15:0] RESET_VAL = 16'h0000;
   localparam logic [15:0] ONE = 16'h0001;
endpackage

/* hw/ppg_top.sv */
// Multi-channel power PWM generator with triggers and interrupt
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ppg_top
   import ppg_pkg::*;
#(
   parameter int CH_NUM = 4
) (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic [DATA_W-1:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [DATA_W-1:0] RDATA_OUT,
   output logic [CH_NUM-1:0] PWM_H_OUT,
   output logic [CH_NUM-1:0] PWM_L_OUT,
   output logic [CH_NUM-1:0] PWM_H_OE_OUT,
   output logic [CH_NUM-1:0] PWM_L_OE_OUT,
   output logic [CH_NUM-1:0] TRIG1_OUT,
   output logic [CH_NUM-1:0] TRIG2_OUT,
   output logic SEV_TRIG_OUT,
   output logic IRQ_OUT
);
   if (CH_NUM < 1 || CH_NUM > CH_MAX) begin : g_bad_ch
      $error("CH_NUM must lie between 1 and 15");
   end

   logic [15:0] tb_ctrl_reg, period_buf_reg, period_reg, mduty_reg, sev_reg;
   logic [15:0] int_stat_reg, int_mask_reg, master_cnt_reg;
   logic [15:0] ch_ctrl_reg [CH_NUM];
   logic [15:0] duty_buf_reg [CH_NUM];
   logic [15:0] duty_reg [CH_NUM];
   logic [15:0] phase_buf_reg [CH_NUM];
   logic [15:0] dead_reg [CH_NUM];
   logic [15:0] out_ctrl_reg [CH_NUM];
   logic [15:0] trig_reg [CH_NUM];
   logic [15:0] strig_reg [CH_NUM];
   logic [15:0] trg_ctrl_reg [CH_NUM];
   logic [15:0] cper_buf_reg [CH_NUM];
   logic [15:0] cper_reg [CH_NUM];
   logic [15:0] cnt_reg [CH_NUM];
   logic [15:0] dt_cnt_reg [CH_NUM];
   logic [3:0] ovr_act_reg [CH_NUM];
   logic [5:0] strt_cnt_reg [CH_NUM];
   logic [3:0] div1_reg [CH_NUM];
   logic [3:0] div2_reg [CH_NUM];
   logic [CH_NUM-1:0] pp_reg, raw_q_reg, swap_q_reg;

   logic enable, master_roll, gl_sel;
   logic [3:0] sel_ch;
   logic [15:0] int_stat_next;
   logic [CH_NUM-1:0] wrap, bnd, raw, blank, gen_h, gen_l, hit1, hit2, started;
   logic [15:0] cur_per [CH_NUM];
   logic [3:0] ovr_eff [CH_NUM];

   assign enable = tb_ctrl_reg[MODULE_ENABLE_BIT];
   assign master_roll = enable && (master_cnt_reg >= period_reg);
   assign gl_sel = (ADDR_IN[7:4] == 4'h0);
   assign sel_ch = ADDR_IN[7:4] - 4'h1;

   // Per-channel time base, waveform and trigger match terms
   always_comb begin
      for (int i = 0; i < CH_NUM; i++) begin
         logic independent_time_base_sel;
         logic [1:0] md;
         logic bh, bl, sw;
         independent_time_base_sel = ch_ctrl_reg[i][INDEPENDENT_TIME_BASE_SEL];
         md = out_ctrl_reg[i][MODE_HI:MODE_LO];
         cur_per[i] = independent_time_base_sel ? cper_reg[i] : period_reg;
         wrap[i] = enable && (cnt_reg[i] >= cur_per[i]);
         bnd[i] = independent_time_base_sel ? wrap[i] : master_roll;
         raw[i] = enable && (cnt_reg[i] < duty_reg[i]);
         bh = raw[i];
         bl = raw[i];
         if (md == MODE_COMP) begin
            bl = enable && !raw[i];
         end else if (md == MODE_PUSH_PULL) begin
            bh = raw[i] && !pp_reg[i];
            bl = raw[i] && pp_reg[i];
         end
         sw = out_ctrl_reg[i][SWAP_BIT];
         gen_h[i] = sw ? bl : bh;
         gen_l[i] = sw ? bh : bl;
         blank[i] = (md == MODE_COMP) && (dt_cnt_reg[i] != RESET_VAL ||
                    ((raw[i] != raw_q_reg[i] || sw != swap_q_reg[i]) &&
                     dead_reg[i] != RESET_VAL));
         hit1[i] = enable && (cnt_reg[i] == trig_reg[i]);
         hit2[i] = enable && (cnt_reg[i] == strig_reg[i]);
         started[i] = (strt_cnt_reg[i] == trg_ctrl_reg[i][TRG_STRT_HI:TRG_STRT_LO]);
         // Unsynced override skips the boundary capture stage
         ovr_eff[i] = out_ctrl_reg[i][OVR_SYNC_BIT] ? ovr_act_reg[i]
                      : {out_ctrl_reg[i][HIGH_OVERRIDE_ENABLE:LOW_OVERRIDE_ENABLE],
                         out_ctrl_reg[i][OVR_DATA_HI:OVR_DATA_LO]};
      end
   end

   // Global control registers
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         tb_ctrl_reg <= RESET_VAL;
         period_buf_reg <= RESET_VAL;
         mduty_reg <= RESET_VAL;
         sev_reg <= RESET_VAL;
         int_mask_reg <= RESET_VAL;
      end else if (WR_IN && gl_sel) begin
         case (ADDR_IN[3:0])
            TB_CTRL_OFS: tb_ctrl_reg <= WDATA_IN;
            PERIOD_OFS: period_buf_reg <= WDATA_IN;
            MDUTY_OFS: mduty_reg <= WDATA_IN;
            SEV_OFS: sev_reg <= WDATA_IN;
            INT_MASK_OFS: int_mask_reg <= WDATA_IN;
            default: ;
         endcase
      end
   end

   // Master time base and its period
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         master_cnt_reg <= RESET_VAL;
         period_reg <= RESET_VAL;
      end else begin
         if (!enable) begin
            master_cnt_reg <= RESET_VAL;
         end else if (master_roll) begin
            master_cnt_reg <= RESET_VAL;
         end else begin
            master_cnt_reg <= master_cnt_reg + ONE;
         end
         if (tb_ctrl_reg[IMMEDIATE_PERIOD_UPDATE_BIT] || master_roll || !enable) begin
            period_reg <= period_buf_reg;
         end
      end
   end

   // Channel registers written by software
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < CH_NUM; i++) begin
            ch_ctrl_reg[i] <= RESET_VAL;
            duty_buf_reg[i] <= RESET_VAL;
            phase_buf_reg[i] <= RESET_VAL;
            dead_reg[i] <= RESET_VAL;
            out_ctrl_reg[i] <= RESET_VAL;
            trig_reg[i] <= RESET_VAL;
            strig_reg[i] <= RESET_VAL;
            trg_ctrl_reg[i] <= RESET_VAL;
            cper_buf_reg[i] <= RESET_VAL;
         end
      end else if (WR_IN && !gl_sel) begin
         for (int i = 0; i < CH_NUM; i++) begin
            if (sel_ch == 4'(i)) begin
               case (ADDR_IN[3:0])
                  CH_CTRL_OFS: ch_ctrl_reg[i] <= WDATA_IN;
                  DUTY_OFS: duty_buf_reg[i] <= WDATA_IN;
                  PHASE_OFS: phase_buf_reg[i] <= WDATA_IN;
                  DEAD_OFS: dead_reg[i] <= WDATA_IN;
                  OUT_CTRL_OFS: out_ctrl_reg[i] <= WDATA_IN;
                  TRIG_OFS: trig_reg[i] <= WDATA_IN;
                  STRIG_OFS: strig_reg[i] <= WDATA_IN;
                  TRG_CTRL_OFS: trg_ctrl_reg[i] <= WDATA_IN;
                  CH_PERIOD_OFS: cper_buf_reg[i] <= WDATA_IN;
                  default: ;
               endcase
            end
         end
      end
   end

   // Channel time bases and active copies of buffered values
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < CH_NUM; i++) begin
            cnt_reg[i] <= RESET_VAL;
            duty_reg[i] <= RESET_VAL;
            cper_reg[i] <= RESET_VAL;
            pp_reg[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < CH_NUM; i++) begin
            if (!enable) begin
               cnt_reg[i] <= RESET_VAL;
               pp_reg[i] <= 1'b0;
            end else if (bnd[i] && !ch_ctrl_reg[i][INDEPENDENT_TIME_BASE_SEL]) begin
               cnt_reg[i] <= phase_buf_reg[i];
            end else if (wrap[i]) begin
               cnt_reg[i] <= RESET_VAL;
            end else begin
               cnt_reg[i] <= cnt_reg[i] + ONE;
            end
            if (enable && (wrap[i] || bnd[i])) begin
               pp_reg[i] <= !pp_reg[i];
            end
            if (ch_ctrl_reg[i][IMMEDIATE_UPDATE_BIT] || bnd[i] || !enable) begin
               duty_reg[i] <= ch_ctrl_reg[i][MASTER_DUTY_SEL] ? mduty_reg
                                                              : duty_buf_reg[i];
            end
            if (tb_ctrl_reg[IMMEDIATE_PERIOD_UPDATE_BIT] || bnd[i] || !enable) begin
               cper_reg[i] <= cper_buf_reg[i];
            end
         end
      end
   end

   // Dead-time blanking and override capture
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < CH_NUM; i++) begin
            dt_cnt_reg[i] <= RESET_VAL;
            ovr_act_reg[i] <= 4'h0;
            raw_q_reg[i] <= 1'b0;
            swap_q_reg[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < CH_NUM; i++) begin
            raw_q_reg[i] <= raw[i];
            swap_q_reg[i] <= out_ctrl_reg[i][SWAP_BIT];
            if ((raw[i] != raw_q_reg[i] || out_ctrl_reg[i][SWAP_BIT] != swap_q_reg[i])
                && dead_reg[i] != RESET_VAL) begin
               dt_cnt_reg[i] <= dead_reg[i] - ONE;
            end else if (dt_cnt_reg[i] != RESET_VAL) begin
               dt_cnt_reg[i] <= dt_cnt_reg[i] - ONE;
            end
            if (!out_ctrl_reg[i][OVR_SYNC_BIT] || bnd[i] || !enable) begin
               ovr_act_reg[i] <= {out_ctrl_reg[i][HIGH_OVERRIDE_ENABLE:LOW_OVERRIDE_ENABLE],
                                  out_ctrl_reg[i][OVR_DATA_HI:OVR_DATA_LO]};
            end
         end
      end
   end

   // Registered pin drive with ownership and override
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         PWM_H_OUT <= '0;
         PWM_L_OUT <= '0;
         PWM_H_OE_OUT <= '0;
         PWM_L_OE_OUT <= '0;
      end else begin
         for (int i = 0; i < CH_NUM; i++) begin
            PWM_H_OE_OUT[i] <= out_ctrl_reg[i][HIGH_PIN_OWNERSHIP];
            PWM_L_OE_OUT[i] <= out_ctrl_reg[i][LOW_PIN_OWNERSHIP];
            PWM_H_OUT[i] <= ovr_eff[i][3] ? ovr_eff[i][1]
                                           : (gen_h[i] && !blank[i]);
            PWM_L_OUT[i] <= ovr_eff[i][2] ? ovr_eff[i][0]
                                           : (gen_l[i] && !blank[i]);
         end
      end
   end

   // Trigger start delay, dividers and trigger pulses
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         TRIG1_OUT <= '0;
         TRIG2_OUT <= '0;
         for (int i = 0; i < CH_NUM; i++) begin
            strt_cnt_reg[i] <= 6'h00;
            div1_reg[i] <= 4'h0;
            div2_reg[i] <= 4'h0;
         end
      end else begin
         for (int i = 0; i < CH_NUM; i++) begin
            TRIG1_OUT[i] <= 1'b0;
            TRIG2_OUT[i] <= 1'b0;
            if (!enable) begin
               strt_cnt_reg[i] <= 6'h00;
               div1_reg[i] <= 4'h0;
               div2_reg[i] <= 4'h0;
            end else begin
               if (!started[i] && wrap[i]) begin
                  strt_cnt_reg[i] <= strt_cnt_reg[i] + 6'h01;
               end
               if (started[i] && hit1[i]) begin
                  if (div1_reg[i] == trg_ctrl_reg[i][TRG_DIV_HI:TRG_DIV_LO]) begin
                     div1_reg[i] <= 4'h0;
                     TRIG1_OUT[i] <= 1'b1;
                  end else begin
                     div1_reg[i] <= div1_reg[i] + 4'h1;
                  end
               end
               if (started[i] && hit2[i]) begin
                  if (div2_reg[i] == trg_ctrl_reg[i][TRG_DIV_HI:TRG_DIV_LO]) begin
                     div2_reg[i] <= 4'h0;
                     TRIG2_OUT[i] <= 1'b1;
                  end else begin
                     div2_reg[i] <= div2_reg[i] + 4'h1;
                  end
               end
            end
         end
      end
   end

   // Interrupt status: set wins over a write-one clear
   always_comb begin
      int_stat_next = int_stat_reg;
      if (WR_IN && gl_sel && ADDR_IN[3:0] == INT_STAT_OFS) begin
         int_stat_next = int_stat_reg & ~WDATA_IN;
      end
      if (enable && master_cnt_reg == sev_reg) begin
         int_stat_next[0] = 1'b1;
      end
      for (int i = 0; i < CH_NUM; i++) begin
         if (TRIG1_OUT[i]) begin
            int_stat_next[i+1] = 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         int_stat_reg <= RESET_VAL;
         IRQ_OUT <= 1'b0;
         SEV_TRIG_OUT <= 1'b0;
      end else begin
         int_stat_reg <= int_stat_next;
         IRQ_OUT <= |(int_stat_next & int_mask_reg);
         SEV_TRIG_OUT <= enable && (master_cnt_reg == sev_reg);
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         RDATA_OUT <= RESET_VAL;
      end else begin
         RDATA_OUT <= RESET_VAL;
         if (RD_IN && gl_sel) begin
            case (ADDR_IN[3:0])
               TB_CTRL_OFS: RDATA_OUT <= tb_ctrl_reg;
               PERIOD_OFS: RDATA_OUT <= period_buf_reg;
               MDUTY_OFS: RDATA_OUT <= mduty_reg;
               SEV_OFS: RDATA_OUT <= sev_reg;
               INT_STAT_OFS: RDATA_OUT <= int_stat_reg;
               INT_MASK_OFS: RDATA_OUT <= int_mask_reg;
               TB_CNT_OFS: RDATA_OUT <= master_cnt_reg;
               default: RDATA_OUT <= RESET_VAL;
            endcase
         end else if (RD_IN) begin
            for (int i = 0; i < CH_NUM; i++) begin
               if (sel_ch == 4'(i)) begin
                  case (ADDR_IN[3:0])
                     CH_CTRL_OFS: RDATA_OUT <= ch_ctrl_reg[i];
                     DUTY_OFS: RDATA_OUT <= duty_buf_reg[i];
                     PHASE_OFS: RDATA_OUT <= phase_buf_reg[i];
                     DEAD_OFS: RDATA_OUT <= dead_reg[i];
                     OUT_CTRL_OFS: RDATA_OUT <= out_ctrl_reg[i];
                     TRIG_OFS: RDATA_OUT <= trig_reg[i];
                     STRIG_OFS: RDATA_OUT <= strig_reg[i];
                     TRG_CTRL_OFS: RDATA_OUT <= trg_ctrl_reg[i];
                     CH_PERIOD_OFS: RDATA_OUT <= cper_buf_reg[i];
                     CH_CNT_OFS: RDATA_OUT <= cnt_reg[i];
                     default: RDATA_OUT <= RESET_VAL;
                  endcase
               end
            end
         end
      end
   end
endmodule

/* dv/ppg_sw_model.sv */
// Behavioural model of the switch drivers and converter trigger inputs
`timescale 1ns/1ps
module ppg_sw_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clr_in,
   input wire logic pp_on_in,
   input wire logic h_in,
   input wire logic l_in,
   input wire logic t1_in,
   input wire logic t2_in,
   input wire logic sev_in,
   output logic [15:0] hi_n_out,
   output logic [15:0] lo_n_out,
   output logic [15:0] t1_n_out,
   output logic [15:0] t2_n_out,
   output logic [15:0] sev_n_out,
   output logic pp_err_out
);
   logic h_d, l_d;
   logic [1:0] last;
   // On-time and trigger counts, push-pull pulse order
   always_ff @(posedge clk_in) begin
      h_d <= h_in;
      l_d <= l_in;
      if (rst_in || clr_in) begin
         hi_n_out <= 16'h0000;
         lo_n_out <= 16'h0000;
         t1_n_out <= 16'h0000;
         t2_n_out <= 16'h0000;
         sev_n_out <= 16'h0000;
         pp_err_out <= 1'b0;
      end else begin
         hi_n_out <= hi_n_out + 16'(h_in);
         lo_n_out <= lo_n_out + 16'(l_in);
         t1_n_out <= t1_n_out + 16'(t1_in);
         t2_n_out <= t2_n_out + 16'(t2_in);
         sev_n_out <= sev_n_out + 16'(sev_in);
         if ((h_in && !h_d && last == 2'h1) || (l_in && !l_d && last == 2'h2)) begin
            pp_err_out <= pp_on_in;
         end
      end
      if (!pp_on_in) begin
         last <= 2'h0;
      end else if (h_in && !h_d) begin
         last <= 2'h1;
      end else if (l_in && !l_d) begin
         last <= 2'h2;
      end
   end
endmodule

/* dv/ppg_top_assertions.sv */
// Port-level checker for the power PWM generator
`timescale 1ns/1ps
module ppg_chk
   import ppg_pkg::*;
#(
   parameter int CH_NUM = 4
) (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic [DATA_W-1:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [DATA_W-1:0] RDATA_OUT,
   input wire logic [CH_NUM-1:0] PWM_H_OUT,
   input wire logic [CH_NUM-1:0] PWM_L_OUT,
   input wire logic [CH_NUM-1:0] PWM_H_OE_OUT,
   input wire logic [CH_NUM-1:0] PWM_L_OE_OUT,
   input wire logic [CH_NUM-1:0] TRIG1_OUT,
   input wire logic [CH_NUM-1:0] TRIG2_OUT,
   input wire logic SEV_TRIG_OUT,
   input wire logic IRQ_OUT
);
   logic [5:0] cfg_reg;
   // Mode, override enables and data of channel 0
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cfg_reg <= 6'h00;
      end else if (WR_IN && ADDR_IN == 8'h14) begin
         cfg_reg <= WDATA_IN[11:6];
      end
   end
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   sequence s_cfg(logic [3:0] m);
      cfg_reg[5:2] == m && $past(cfg_reg) == cfg_reg && $past(cfg_reg, 2) == cfg_reg;
   endsequence
   property p_rd_idle;
      !$past(RD_IN) |-> RDATA_OUT == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_trig_pulse;
      TRIG1_OUT[0] |=> !TRIG1_OUT[0];
   endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
   property p_sev_pulse;
      SEV_TRIG_OUT |=> !SEV_TRIG_OUT;
   endproperty
   a_sev_pulse: assert property (p_sev_pulse) else $error("event too long");
   property p_irq_cause;
      $rose(IRQ_OUT) |-> SEV_TRIG_OUT || TRIG1_OUT != 0 || $past(SEV_TRIG_OUT)
         || $past(TRIG1_OUT) != 0 || $past(WR_IN) || $past(WR_IN, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
   property p_oe_cause;
      $changed({PWM_H_OE_OUT, PWM_L_OE_OUT}) |-> $past(WR_IN) || $past(WR_IN, 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("ownership changed alone");
   property p_comp;
      s_cfg(4'h0) |-> !(PWM_H_OUT[0] && PWM_L_OUT[0]);
   endproperty
   a_comp: assert property (p_comp) else $error("complementary overlap");
   property p_red;
      s_cfg(4'h4) |-> PWM_H_OUT[0] == PWM_L_OUT[0];
   endproperty
   a_red: assert property (p_red) else $error("redundant outputs differ");
   property p_pp;
      s_cfg(4'h8) |-> !(PWM_H_OUT[0] && PWM_L_OUT[0]);
   endproperty
   a_pp: assert property (p_pp) else $error("push-pull both high");
   property p_ovr;
      WR_IN && ADDR_IN == 8'h14 && WDATA_IN[9:8] == 2'h3 && !WDATA_IN[0]
         |-> ##[1:2] (PWM_H_OUT[0] == cfg_reg[1] && PWM_L_OUT[0] == cfg_reg[0]);
   endproperty
   a_ovr: assert property (p_ovr) else $error("override late");
   c_red: cover property (s_cfg(4'h4) ##1 PWM_H_OUT[0]);
   c_pp: cover property (s_cfg(4'h8) ##1 PWM_L_OUT[0]);
   c_irq: cover property ($rose(IRQ_OUT));
endmodule
bind ppg_top ppg_chk #(.CH_NUM(CH_NUM)) ppg_chk_inst (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
   .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
   .RDATA_OUT(RDATA_OUT), .PWM_H_OUT(PWM_H_OUT), .PWM_L_OUT(PWM_L_OUT),
   .PWM_H_OE_OUT(PWM_H_OE_OUT), .PWM_L_OE_OUT(PWM_L_OE_OUT), .TRIG1_OUT(TRIG1_OUT),
   .TRIG2_OUT(TRIG2_OUT), .SEV_TRIG_OUT(SEV_TRIG_OUT), .IRQ_OUT(IRQ_OUT));

/* dv/testbench.sv */
// Self-checking testbench for the power PWM generator
`timescale 1ns/1ps
module testbench;
   import ppg_pkg::*;
   logic MCLK_IN, RST_IN, WR_IN, RD_IN, SEV_TRIG_OUT, IRQ_OUT, clr, pp_on, pp_err, rd_d;
   logic [7:0] ADDR_IN;
   logic [15:0] WDATA_IN, RDATA_OUT, hi_n, lo_n, t1_n, t2_n, sev_n, d;
   logic [3:0] PWM_H_OUT, PWM_L_OUT, PWM_H_OE_OUT, PWM_L_OE_OUT, TRIG1_OUT, TRIG2_OUT;
   logic [15:0] exp_q [$];
   logic [15:0] oc [9] = '{16'hc400, 16'hc400, 16'hc800, 16'hc380, 16'hc400, 16'hc400,
      16'hc002, 16'hc000, 16'hcc00};
   logic [15:0] cc [9] = '{16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0200,
      16'h0000, 16'h0000, 16'h0000};
   logic [3:0] du [9] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h0, 4'h1, 4'h2, 4'h2, 4'h2};
   logic [7:0] eh [9] = '{8'h14, 8'h0a, 8'h0a, 8'h28, 8'h00, 8'h14, 8'h0a, 8'h0a, 8'h14};
   logic [7:0] el [9] = '{8'h14, 8'h0a, 8'h0a, 8'h00, 8'h00, 8'h14, 8'h0a, 8'h0a, 8'h14};
   logic [15:0] tc [4] = '{16'h0000, 16'h1000, 16'h3000, 16'h0002};
   logic [7:0] et [4] = '{8'h0c, 8'h06, 8'h03, 8'h0a};
   int n_mismatch, num_checks;
   ppg_top #(.CH_NUM(4)) ppg_top_inst (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
      .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
      .PWM_H_OUT(PWM_H_OUT), .PWM_L_OUT(PWM_L_OUT), .PWM_H_OE_OUT(PWM_H_OE_OUT),
      .PWM_L_OE_OUT(PWM_L_OE_OUT), .TRIG1_OUT(TRIG1_OUT), .TRIG2_OUT(TRIG2_OUT),
      .SEV_TRIG_OUT(SEV_TRIG_OUT), .IRQ_OUT(IRQ_OUT));
   ppg_sw_model ppg_sw_model_inst (.clk_in(MCLK_IN), .rst_in(RST_IN), .clr_in(clr),
      .pp_on_in(pp_on), .h_in(PWM_H_OUT[0]), .l_in(PWM_L_OUT[0]), .t1_in(TRIG1_OUT[0]),
      .t2_in(TRIG2_OUT[0]), .sev_in(SEV_TRIG_OUT), .hi_n_out(hi_n), .lo_n_out(lo_n),
      .t1_n_out(t1_n), .t2_n_out(t2_n), .sev_n_out(sev_n), .pp_err_out(pp_err));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
      cmp(got, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      ADDR_IN <= a;
      WDATA_IN <= v;
      WR_IN <= 1'b1;
      @(posedge MCLK_IN);
      WR_IN <= 1'b0;
      @(posedge MCLK_IN);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] v);
      ADDR_IN <= a;
      RD_IN <= 1'b1;
      exp_q.push_back(v);
      @(posedge MCLK_IN);
      RD_IN <= 1'b0;
      @(posedge MCLK_IN);
   endtask
   task automatic run(input int n);
      clr <= 1'b1;
      @(posedge MCLK_IN);
      clr <= 1'b0;
      repeat (n) @(posedge MCLK_IN);
      @(negedge MCLK_IN);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge MCLK_IN) begin
      rd_d <= RD_IN;
   end
   always @(negedge MCLK_IN) begin
      if (rd_d === 1'b1) begin
         cmp(RDATA_OUT, exp_q.pop_front());
      end
   end
   initial begin
      MCLK_IN = 1'b0;
      forever #50 MCLK_IN = ~MCLK_IN;
   end
   initial begin
      repeat (20000) @(posedge MCLK_IN);
      n_mismatch++;
      $display("watchdog expired");
      tally_and_finish();
   end
   initial begin
      RST_IN = 1'b1;
      WR_IN = 1'b0;
      RD_IN = 1'b0;
      ADDR_IN = 8'h00;
      WDATA_IN = 16'h0000;
      clr = 1'b0;
      pp_on = 1'b0;
      d = 16'($urandom(32'h78d3));
      repeat (3) @(posedge MCLK_IN);
      RST_IN <= 1'b0;
      rd(8'h00, 16'h0000);
      rd(8'h04, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         d = 16'($urandom);
         wr(8'h0f, d);
         rd(8'h0f, 16'h0000);
         wr(8'h60, d);
         rd(8'h60, 16'h0000);
         wr(8'h01, d);
         rd(8'h01, d);
      end
      $display("test registers done");
      wr(8'h01, 16'h0003);
      wr(8'h02, 16'h0001);
      wr(8'h13, 16'h0001);
      wr(8'h00, 16'h8000);
      for (int i = 0; i < 9; i++) begin
         pp_on <= oc[i][11:10] == 2'h2;
         wr(8'h10, cc[i]);
         wr(8'h11, {12'h000, du[i]});
         wr(8'h18, 16'h0001);
         wr(8'h14, oc[i]);
         repeat (12) @(posedge MCLK_IN);
         run(40);
         cmp_cnt(hi_n, {8'h00, eh[i]});
         cmp_cnt(lo_n, {8'h00, el[i]});
         cmp_cnt({8'h00, PWM_H_OE_OUT, PWM_L_OE_OUT}, 16'h0011);
         @(posedge MCLK_IN);
      end
      $display("test modes done");
      pp_on <= 1'b1;
      wr(8'h14, 16'hc800);
      wr(8'h00, 16'h8400);
      run(4);
      @(posedge MCLK_IN);
      repeat (30) begin
         wr(8'h01, 16'(3 + $urandom_range(3)));
         repeat ($urandom_range(5)) @(posedge MCLK_IN);
      end
      cmp_cnt({15'h0000, pp_err}, 16'h0000);
      $display("test push-pull done");
      pp_on <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         wr(8'h00, 16'h0000);
         wr(8'h10, 16'(i));
         wr(8'h11, 16'h0000);
         wr(8'h01, 16'h00c7);
         wr(8'h14, 16'hc400);
         wr(8'h00, 16'h8000);
         wr(8'h11, 16'h0096);
         wr(8'h12, 16'h0010);
         rd(8'h19, 16'h0005);
         wr(8'h12, 16'h0000);
         run(20);
         cmp_cnt(hi_n, (i == 1) ? 16'h0014 : 16'h0000);
         @(posedge MCLK_IN);
      end
      $display("test update done");
      for (int j = 0; j < 4; j++) begin
         wr(8'h00, 16'h0000);
         wr(8'h01, 16'h0009);
         wr(8'h15, 16'h0008);
         wr(8'h16, 16'h0008);
         wr(8'h03, 16'h0005);
         wr(8'h05, 16'h0003);
         wr(8'h17, tc[j]);
         wr(8'h00, 16'h8000);
         run(122);
         cmp_cnt(t1_n, {8'h00, et[j]});
         cmp_cnt(t2_n, {8'h00, et[j]});
         cmp_cnt(sev_n, 16'h000c);
         @(posedge MCLK_IN);
         wr(8'h00, 16'h0000);
         cmp_cnt({15'h0000, IRQ_OUT}, 16'h0001);
         rd(8'h04, 16'h001f);
         wr(8'h05, 16'h0000);
         @(posedge MCLK_IN);
         cmp_cnt({15'h0000, IRQ_OUT}, 16'h0000);
         wr(8'h04, 16'h001f);
         rd(8'h04, 16'h0000);
      end
      $display("test triggers done");
      tally_and_finish();
   end
endmodule
